// *** acquire_checker.sv ***
// Checker for the test-mode acquire sequencer.
// Assumes it is bound to the sequencer and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module acquire_checker #(
  parameter [27:0] LITE_UP_CYCLES = 28'h000F424,
  parameter [27:0] BOOT_CYCLES = 28'h002AB98,
  parameter [27:0] CYCLES_PER_MS = 28'h003D090
) (
  input wire logic i_clk,               // Core clock
  input wire logic i_nrst,              // Reset, active low
  input wire logic o_internal_reset,    // Internal reset
  input wire logic o_boot_running,      // Boot busy
  input wire logic o_listen_open,       // Window open
  input wire logic o_ident_ready,       // Ident answers allowed
  input wire logic o_test_mode,         // Test mode
  input wire logic o_run_user,          // User code
  input wire logic o_debug_link_active, // Probe seen
  input wire logic o_cpu_debug_ctl,     // Probe owns CPU
  input wire logic o_link_edge          // Link edge pulse
);
  // Slack of a few cycles covers the internal state hand-over
  localparam int LU = LITE_UP_CYCLES + 4;
  localparam int BLO = BOOT_CYCLES - 1;
  localparam int BHI = BOOT_CYCLES + 4;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  chk_lite_up_len: assert property (o_internal_reset |-> ##[0:LU] !o_internal_reset) else $error("long reset");
  chk_boot_len: assert property ($rose(o_boot_running) |-> ##[BLO:BHI] !o_boot_running) else $error("boot length");
  chk_test_entry: assert property ($rose(o_test_mode) |-> $past(o_listen_open)) else $error("test entry");
  chk_no_user: assert property (!(o_test_mode && o_run_user)) else $error("user in test");
  chk_cpu_ctl: assert property (o_cpu_debug_ctl == o_test_mode) else $error("cpu control");
  chk_link_sticky: assert property (o_debug_link_active |=> o_debug_link_active) else $error("link flag");
  chk_link_set: assert property ($rose(o_debug_link_active) |-> $past(o_listen_open)) else $error("link set");
  chk_window_shut: assert property (o_run_user |=> !o_test_mode && o_run_user) else $error("late entry");
  chk_ident_boot: assert property (o_boot_running |-> !o_ident_ready) else $error("early ident");
  chk_edge_pulse: assert property (o_link_edge |=> !o_link_edge) else $error("edge pulse");
endmodule // acquire_checker
bind test_mode_acquire acquire_checker #(.LITE_UP_CYCLES(LITE_UP_CYCLES), .BOOT_CYCLES(BOOT_CYCLES),
  .CYCLES_PER_MS(CYCLES_PER_MS)) chk (.i_clk, .i_nrst, .o_internal_reset, .o_boot_running, .o_listen_open,
  .o_ident_ready, .o_test_mode, .o_run_user, .o_debug_link_active, .o_cpu_debug_ctl, .o_link_edge);
`default_nettype wire

// *** acquire_map.vh ***
// Constants for the boot-time test-mode acquisition block.
// Assumes a 250 MHz core clock; times are kept in their own units.
// Summary of operation
// - Internal reset lasts at most 250 us after reset release.
// - Boot takes 0.7 ms to 600 ms before debug lines open.
// - Listen window lasts 20 ms by default, configurable 0 to 100 ms.
// - Valid connection in window enters test mode, else user code starts.
// - Test mode gives programmer CPU control and blocks user code.
// - Program counter read must fall in ROM or supervisory flash.
// - Device flags an active debug link once a probe connects in window.
// - Alternate path needs unrepurposed pins and permissive access settings.
// - Device answers identification read only once boot is done.
`ifndef ACQUIRE_MAP_VH
`define ACQUIRE_MAP_VH
`define CLK_MHZ 250
`define LITE_UP_US 250
`define BOOT_MIN_US 700
`define BOOT_MAX_MS 600
`define LISTEN_DEF_MS 20
`define LISTEN_MAX_MS 100
`define CYC_PER_MS (`CLK_MHZ * 1000)
`define LITE_UP_CYC (`LITE_UP_US * `CLK_MHZ)
`define BOOT_MIN_CYC (`BOOT_MIN_US * `CLK_MHZ)
`define LISTEN_DEF_CYC (`LISTEN_DEF_MS * `CYC_PER_MS)
`define TEST_FLAG_BIT 31
`define PC_SELECT_VALUE 32'h0000000F
`define CNT_W 28
`endif

// *** prog_model.sv ***
// Programmer model: link clock frames, then handshake and flag write.
// Assumes the bench raises i_go to start one acquire attempt per rise.
`timescale 1ns/100ps
`default_nettype none
module prog_model (
  input wire logic i_go,     // Attempt acquire
  output logic o_link_clk,   // Link clock, idle low
  output logic o_conn,       // Handshake done
  output logic o_flag        // Flag write done
);
  initial o_link_clk = 0;
  initial o_conn = 0;
  initial o_flag = 0;
  // Clock only runs in frames; 48 ns period is well above the minimum rate
  always begin
    wait (i_go);
    repeat (8) begin
      #24 o_link_clk = 1;
      #24 o_link_clk = 0;
    end
    o_conn = i_go;
    #48 o_flag = i_go;
    wait (!i_go);
    o_conn = 0;
    o_flag = 0;
  end
endmodule // prog_model
`default_nettype wire

// *** pulse_timer.v ***
// One-shot cycle counter: loads a count on start, pulses done at zero.
// Assumes start and count come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
module pulse_timer (
  input wire i_clk,             // Core clock
  input wire i_nrst,            // Async reset, active low
  input wire i_start,           // Load count and run
  input wire [27:0] i_count,    // Cycles to wait
  output reg o_done             // One-cycle pulse at expiry
);
  reg [27:0] remain;
  reg running;
  // Count down; a zero load expires on the next cycle
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      remain <= 28'h0000000;
      running <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_start) begin
        remain <= i_count;
        running <= 1'b1;
      end else if (running) begin
        if (remain == 28'h0000000) begin
          running <= 1'b0;
          o_done <= 1'b1;
        end else begin
          remain <= remain - 28'h0000001;
        end
      end
    end
  end
endmodule // pulse_timer
`default_nettype wire

// *** test_mode_acquire.v ***
// Boot sequencer: internal reset, boot, listen window, then test mode or user code.
// Assumes the debug port front end decodes link transactions and reports
// handshake and test-flag writes as held levels; both are synchronised to the core clock here.
`timescale 1ns/100ps
`default_nettype none
`include "acquire_map.vh"
module test_mode_acquire #(
  parameter [27:0] LITE_UP_CYCLES = `LITE_UP_CYC,   // Internal reset length
  parameter [27:0] BOOT_CYCLES = `BOOT_MIN_CYC,      // Boot code duration
  parameter [27:0] CYCLES_PER_MS = `CYC_PER_MS       // Window scale
) (
  input wire i_clk,               // Core clock, 250 MHz
  input wire i_nrst,              // Async reset, active low
  input wire i_link_clk,          // Debug link clock pin
  input wire i_conn_seq,          // Connection sequence seen (pin domain)
  input wire i_flag_write,        // Test flag bit write seen (pin domain)
  input wire i_use_default,       // Window config absent: use default
  input wire [6:0] i_listen_ms,   // Window length from boot table, ms
  input wire i_pins_repurposed,   // Firmware took the debug pins
  input wire i_access_allowed,    // Protection settings allow debug access
  output reg o_internal_reset,    // Internal reset held
  output reg o_boot_running,      // Boot code executing
  output reg o_listen_open,       // Listen window open
  output reg o_ident_ready,       // May acknowledge identification reads
  output reg o_test_mode,         // Test mode register flag
  output reg o_run_user,          // Start user code from application flash
  output reg o_debug_link_active, // Probe connected in window
  output reg o_cpu_debug_ctl,     // Programmer controls CPU and SRAM
  output reg o_link_edge          // Rising edge of link clock seen
);
  localparam ST_RESET = 3'h0;
  localparam ST_BOOT = 3'h1;
  localparam ST_LISTEN = 3'h2;
  localparam ST_TEST = 3'h3;
  localparam ST_USER = 3'h4;

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers for pin inputs
  reg [2:0] lclk_sync;
  reg [1:0] conn_sync;
  reg [1:0] flag_sync;
  reg [1:0] rep_sync;
  reg [1:0] acc_sync;
  // Two flops each; link clock gets a third for edge finding
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      lclk_sync <= 3'h0;
      conn_sync <= 2'h0;
      flag_sync <= 2'h0;
      rep_sync <= 2'h0;
      acc_sync <= 2'h0;
    end else begin
      lclk_sync <= {lclk_sync[1:0], i_link_clk};
      conn_sync <= {conn_sync[0], i_conn_seq};
      flag_sync <= {flag_sync[0], i_flag_write};
      rep_sync <= {rep_sync[0], i_pins_repurposed};
      acc_sync <= {acc_sync[0], i_access_allowed};
    end
  end

  wire link_rise = lclk_sync[1] & ~lclk_sync[2];
  wire conn = conn_sync[1];
  wire flag_wr = flag_sync[1];
  wire alt_ok = ~rep_sync[1] & acc_sync[1];

  // Edge marker for the link front end
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) o_link_edge <= 1'b0;
    else o_link_edge <= link_rise;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Window length: ms count scaled, capped at the maximum
  function [27:0] ms_to_cyc;
    input [6:0] ms;
    reg [6:0] capped;
    begin
      capped = (ms > `LISTEN_MAX_MS) ? 7'd100 : ms;
      ms_to_cyc = capped * CYCLES_PER_MS;
    end
  endfunction

  wire [27:0] listen_cyc = i_use_default ? ms_to_cyc(7'd20) : ms_to_cyc(i_listen_ms);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer state and shared timer
  reg [2:0] state;
  reg [2:0] next_state;
  reg tmr_start;
  reg [27:0] tmr_count;
  reg started;
  wire tmr_done;

  pulse_timer u_timer (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_start(tmr_start),
    .i_count(tmr_count),
    .o_done(tmr_done)
  );

  // Next state and timer loads
  always @* begin
    next_state = state;
    tmr_start = 1'b0;
    tmr_count = 28'h0000000;
    case (state)
      ST_RESET: begin
        tmr_count = LITE_UP_CYCLES;
        tmr_start = ~started;
        if (tmr_done) begin
          next_state = ST_BOOT;
          tmr_start = 1'b1;
          tmr_count = BOOT_CYCLES;
        end
      end
      ST_BOOT: begin
        if (tmr_done) begin
          next_state = ST_LISTEN;
          tmr_start = 1'b1;
          tmr_count = listen_cyc;
        end
      end
      ST_LISTEN: begin
        if (conn && flag_wr)
          next_state = ST_TEST;
        else if (tmr_done)
          next_state = ST_USER;
      end
      ST_TEST: next_state = ST_TEST;
      ST_USER: next_state = ST_USER;
      default: next_state = ST_RESET;
    endcase
  end

  // State register; started guards the one-time timer load
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state <= ST_RESET;
      started <= 1'b0;
    end else begin
      state <= next_state;
      started <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs decoded from next state
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_internal_reset <= 1'b1;
      o_boot_running <= 1'b0;
      o_listen_open <= 1'b0;
      o_ident_ready <= 1'b0;
      o_test_mode <= 1'b0;
      o_run_user <= 1'b0;
      o_cpu_debug_ctl <= 1'b0;
    end else begin
      o_internal_reset <= (next_state == ST_RESET);
      o_boot_running <= (next_state == ST_BOOT);
      o_listen_open <= (next_state == ST_LISTEN);
      // Alternate path can still answer in user code if pins are free and access is allowed
      o_ident_ready <= (next_state == ST_LISTEN) || (next_state == ST_TEST) ||
                       ((next_state == ST_USER) && alt_ok);
      o_test_mode <= (next_state == ST_TEST);
      o_run_user <= (next_state == ST_USER);
      // CPU held in boot code while the programmer owns it
      o_cpu_debug_ctl <= (next_state == ST_TEST);
    end
  end

  // Sticky until reset; firmware reads it before touching the pins
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) o_debug_link_active <= 1'b0;
    else if ((state == ST_LISTEN) && conn) o_debug_link_active <= 1'b1;
  end
endmodule // test_mode_acquire
`default_nettype wire

// *** test_test_mode_acquire.sv ***
// Bench for the test-mode acquire sequencer with a programmer model.
// Assumes shortened boot counts given through parameters.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_count++; $display("MISMATCH %0t value", $time); end end
module test_test_mode_acquire;
  logic i_clk = 0, i_nrst = 0, i_use_default = 0, i_pins_repurposed = 0, i_access_allowed = 1, go = 0, seen = 0;
  logic [6:0] i_listen_ms = 0;
  logic [1:0] exp_q[$];
  int err_count = 0, num_checks = 0, edges = 0;
  wire link_clk, conn, flag, o_ir, o_br, o_lo, o_ident_ready, o_test_mode, o_run_user, o_debug_link_active;
  wire o_link_edge;
  test_mode_acquire #(.LITE_UP_CYCLES(28'hA), .BOOT_CYCLES(28'h14), .CYCLES_PER_MS(28'h5)) dut (.i_clk(i_clk),
    .i_nrst(i_nrst), .i_link_clk(link_clk), .i_conn_seq(conn), .i_flag_write(flag), .i_use_default(i_use_default),
    .i_listen_ms(i_listen_ms), .i_pins_repurposed(i_pins_repurposed), .i_access_allowed(i_access_allowed),
    .o_internal_reset(o_ir), .o_boot_running(o_br), .o_listen_open(o_lo), .o_ident_ready(o_ident_ready),
    .o_test_mode(o_test_mode), .o_run_user(o_run_user), .o_debug_link_active(o_debug_link_active),
    .o_cpu_debug_ctl(), .o_link_edge(o_link_edge));
  prog_model prog (.i_go(go), .o_link_clk(link_clk), .o_conn(conn), .o_flag(flag));
  always #2 i_clk = ~i_clk;
  // Count link edge pulses; each attempt sends one burst of eight
  always @(negedge i_clk) if (o_link_edge === 1'b1) edges++;
  // Monitor takes the oldest note at the first outcome after reset
  always @(negedge i_clk) begin
    if (!i_nrst) seen = 0;
    else if (!seen && (o_test_mode | o_run_user) === 1'b1) begin
      seen = 1;
      `CHK({o_test_mode, o_run_user}, exp_q.pop_front())
    end
  end
  task automatic end_of_test();
    if (err_count == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // One reset-to-outcome pass; a late probe must be ignored
  task automatic run(input logic [6:0] ms, input logic dflt, input logic early);
    int n;
    @(negedge i_clk);
    i_nrst = 0;
    go = 0;
    i_listen_ms = ms;
    i_use_default = dflt;
    i_pins_repurposed = $urandom;
    i_access_allowed = $urandom;
    repeat (10) @(negedge i_clk);
    exp_q.push_back(early ? 2'b10 : 2'b01);
    i_nrst = 1;
    go = early;
    n = 0;
    while ((o_test_mode | o_run_user) !== 1'b1 && n < 900) begin
      @(negedge i_clk);
      n++;
    end
    if (n >= 900) begin
      err_count++;
      end_of_test();
    end
    repeat (4) @(negedge i_clk);
    `CHK(o_debug_link_active, early)
    if (!early) `CHK(o_ident_ready, !i_pins_repurposed & i_access_allowed)
    go = 1;
    // Long enough for the late probe's whole attempt to arrive
    repeat (140) @(negedge i_clk);
    `CHK({o_test_mode, o_run_user}, early ? 2'b10 : 2'b01)
    go = 0;
  endtask
  initial begin
    void'($urandom(32'h7D4CA638));
    run(7'h00, 1'b0, 1'b0);
    run(7'h00, 1'b1, 1'b1);
    run(7'h01 + ($urandom % 3), 1'b0, 1'b0);
    run(7'h1E, 1'b0, 1'b1);
    run(7'h64, 1'b0, 1'b0);
    `CHK(edges, 40)
    end_of_test();
  end
endmodule // test_test_mode_acquire
`default_nettype wire
